/* File: design/olsc_startup_cfg.sv */
// ==========================================
// Contract
// - Bits 30-27 pick the open-loop current cap, codes 0h-Dh from 0.078125 A to 3.75 A.
// - Bits 26-23 pick the linear start-up acceleration, 0.01 Hz/s up to 10000 Hz/s.
// - Bits 22-19 pick the quadratic acceleration, zero at code 0h, 10000 Hz/s2 at the top.
// - Bit 18 set hands over on estimator lock, clear hands over at the speed threshold.
// - Bits 17-13 set the handover speed, 1% steps to 20%, then 2.5% steps to 50%.
// - The settings register sits at index 86h and resets to zero.
// - The table cap applies only while the source select is clear, else the general cap.
`timescale 1ns/1ps
`default_nettype none
module olsc_startup_cfg #(
  parameter int P_TICK_CYCLES = olsc_pkg::RAMP_TICK_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [olsc_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_estimator_locked,
  output logic [olsc_pkg::CAP_W-1:0] o_ol_current_cap,
  output logic [olsc_pkg::ACC_W-1:0] o_ol_freq,
  output logic [1:0] o_ramp_state,
  output logic o_handoff
);
  import olsc_pkg::*;

  olsc_cfg_if cfg ();

  logic ack_reg;
  logic [31:0] settings_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] max_speed_reg;
  logic done_reg;
  logic [31:0] rdata_reg;
  logic [CAP_W-1:0] cap_reg;
  olsc_state_t ramp_state;
  logic [ACC_W-1:0] ramp_freq;
  logic ramp_handoff;

  // ==========================================
  // Bus handshake, one wait cycle per access
  wire req;
  wire first;
  wire wr_en;
  wire rd_first;
  assign req = i_avs_read | i_avs_write;
  assign first = req & ~ack_reg;
  assign wr_en = i_avs_write & ack_reg;
  assign rd_first = i_avs_read & ~ack_reg;
  assign o_avs_waitrequest = first;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= first;
    end
  end

  // ==========================================
  // Address decode
  wire sel_settings;
  wire sel_ctrl;
  wire sel_max_speed;
  wire sel_status;
  wire sel_freq;
  assign sel_settings = i_avs_address == ADDR_SETTINGS;
  assign sel_ctrl = i_avs_address == ADDR_CTRL;
  assign sel_max_speed = i_avs_address == ADDR_MAX_SPEED;
  assign sel_status = i_avs_address == ADDR_STATUS;
  assign sel_freq = i_avs_address == ADDR_FREQ;

  wire [31:0] be_mask;
  assign be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
    {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

  // ==========================================
  // Register write paths
  wire [31:0] settings_m;
  wire [31:0] ctrl_m;
  wire [31:0] speed_m;
  wire [31:0] settings_next;
  wire [31:0] ctrl_next;
  wire [31:0] max_speed_next;
  wire done_clear;
  wire done_next;
  assign settings_m = SETTINGS_WMASK & be_mask;
  assign ctrl_m = CTRL_WMASK & be_mask;
  assign speed_m = MAX_SPEED_WMASK & be_mask;
  assign settings_next = (wr_en && sel_settings) ?
    ((settings_reg & ~settings_m) | (i_avs_writedata & settings_m)) : settings_reg;
  assign ctrl_next = (wr_en && sel_ctrl) ?
    ((ctrl_reg & ~ctrl_m) | (i_avs_writedata & ctrl_m)) : ctrl_reg;
  assign max_speed_next = (wr_en && sel_max_speed) ?
    ((max_speed_reg & ~speed_m) | (i_avs_writedata & speed_m)) : max_speed_reg;
  assign done_clear = wr_en && sel_status && i_avs_byteenable[0] &&
    i_avs_writedata[STATUS_DONE_BIT];
  assign done_next = ramp_handoff | (done_reg & ~done_clear);

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      settings_reg <= SETTINGS_RESET;
      ctrl_reg <= CTRL_RESET;
      max_speed_reg <= MAX_SPEED_RESET;
      done_reg <= 1'b0;
    end else begin
      settings_reg <= settings_next;
      ctrl_reg <= ctrl_next;
      max_speed_reg <= max_speed_next;
      done_reg <= done_next;
    end
  end

  // ==========================================
  // Fields to the decode and ramp
  wire cap_src;
  wire [CAP_W-1:0] general_cap;
  assign cfg.ilim_code = settings_reg[ILIM_LSB +: 4];
  assign cfg.a1_code = settings_reg[A1_LSB +: 4];
  assign cfg.a2_code = settings_reg[A2_LSB +: 4];
  assign cfg.auto_en = settings_reg[AUTO_BIT];
  assign cfg.thr_code = settings_reg[THR_LSB +: 5];
  assign cfg.run = ctrl_reg[CTRL_RUN_BIT];
  assign cfg.max_speed = max_speed_reg[15:0];
  assign cap_src = ctrl_reg[CTRL_SRC_BIT];
  assign general_cap = ctrl_reg[CTRL_GCAP_LSB +: CAP_W];

  olsc_lut u_lut (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .cfg(cfg.lut)
  );

  olsc_ramp #(
    .P_TICK_CYCLES(P_TICK_CYCLES)
  ) u_ramp (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .cfg(cfg.ramp),
    .i_estimator_locked(i_estimator_locked),
    .o_state(ramp_state),
    .o_freq(ramp_freq),
    .o_handoff(ramp_handoff)
  );

  // ==========================================
  // Current cap selection
  wire [CAP_W-1:0] cap_next;
  assign cap_next = cap_src ? general_cap : cfg.table_cap;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cap_reg <= '0;
    end else begin
      cap_reg <= cap_next;
    end
  end

  // ==========================================
  // Read data
  wire [31:0] status_word;
  wire [31:0] freq_word;
  wire [31:0] rd_mux;
  assign status_word = {28'h000_0000, cap_src, ramp_state, done_reg};
  assign freq_word = ramp_freq[FREQ_RD_LSB +: 32];
  assign rd_mux = sel_settings ? settings_reg :
    sel_ctrl ? ctrl_reg :
    sel_max_speed ? max_speed_reg :
    sel_status ? status_word :
    sel_freq ? freq_word : 32'h0000_0000;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_first) begin
      rdata_reg <= rd_mux;
    end
  end

  assign o_avs_readdata = rdata_reg;
  assign o_ol_current_cap = cap_reg;
  assign o_ol_freq = ramp_freq;
  assign o_ramp_state = ramp_state;
  assign o_handoff = ramp_handoff;

  // ==========================================
  // Checks
  sequence s_first_beat;
    first;
  endsequence
  sequence s_settings_write;
    wr_en && sel_settings && (i_avs_byteenable == 4'hF);
  endsequence

  AST_BUS_ONE_WAIT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    s_first_beat |=> !o_avs_waitrequest)
    else $error("Waitrequest held beyond one cycle");
  AST_RESET_ZERO: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $rose(i_rst_n) |-> (settings_reg == 32'h0000_0000))
    else $error("Settings not zero after reset");
  AST_SETTINGS_WRITE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    s_settings_write |=> settings_reg == ($past(i_avs_writedata) & SETTINGS_WMASK))
    else $error("Settings write not stored");
  AST_TABLE_CAP: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (!cap_src && cfg.ilim_code == 4'hD) |=> (o_ol_current_cap == 9'h1E0))
    else $error("Open loop cap not taken from code");
  AST_GENERAL_CAP: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    cap_src |=> (o_ol_current_cap == $past(general_cap)))
    else $error("General cap not used when selected");

  // ==========================================
  // Further checks
  wire any_sel;
  wire [ACC_W-1:0] thr_check;
  assign any_sel = sel_settings | sel_ctrl | sel_max_speed | sel_status | sel_freq;
  assign thr_check = ACC_W'(cfg.max_speed) * ACC_W'(cfg.thr_half_pct) * THR_SCALE;

  sequence s_settings_read;
    rd_first && sel_settings;
  endsequence
  sequence s_unmapped_read;
    rd_first && !any_sel;
  endsequence
  sequence s_below_threshold;
    (ramp_state == OLSC_RAMP) && cfg.run && !cfg.auto_en && (ramp_freq < thr_check);
  endsequence

  AST_SETTINGS_READ: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    s_settings_read |=> (o_avs_readdata == $past(settings_reg)))
    else $error("Settings read data wrong");

  AST_UNMAPPED_READ: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    s_unmapped_read |=> (o_avs_readdata == 32'h0000_0000))
    else $error("Unmapped read not zero");

  AST_UNMAPPED_WRITE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (wr_en && !any_sel) |=> $stable(settings_reg) && $stable(ctrl_reg))
    else $error("Unmapped write changed a register");

  AST_RESERVED_ZERO: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    settings_reg[31] == 1'b0)
    else $error("Reserved settings bit set");

  AST_CAP_CODE_ZERO: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (!cap_src && cfg.ilim_code == 4'h0) |=> (o_ol_current_cap == 9'h00A))
    else $error("Lowest cap code wrong");

  AST_MANUAL_HANDOVER: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    s_below_threshold |=> !o_handoff)
    else $error("Handover below threshold");

  AST_HANDOFF_PULSE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_handoff |=> !o_handoff)
    else $error("Handover pulse too long");

  AST_DONE_SET_WINS: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    ramp_handoff |=> done_reg)
    else $error("Done flag lost on handover");

  AST_DONE_CLEAR: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (done_clear && !ramp_handoff) |=> !done_reg)
    else $error("Done flag not cleared");

  AST_IDLE_CLEARS: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (ramp_state == OLSC_IDLE) |=> (ramp_freq == '0))
    else $error("Frequency not cleared in idle");

  AST_CLOSED_HOLDS: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    ((ramp_state == OLSC_CLOSED) && cfg.run) |=> $stable(ramp_freq))
    else $error("Frequency moved after handover");

  AST_SPEED_WRITE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (wr_en && sel_max_speed && i_avs_byteenable == 4'hF) |=>
    (max_speed_reg == ($past(i_avs_writedata) & MAX_SPEED_WMASK)))
    else $error("Max speed write not stored");
endmodule
`default_nettype wire

/* File: design/olsc_pkg.sv */
`default_nettype none
package olsc_pkg;
  // ==========================================
  // Timing
  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int RAMP_TICK_US = 1000;
  localparam int RAMP_TICK_CYCLES = CLK_FREQ_HZ / 1_000_000 * RAMP_TICK_US;

  // ==========================================
  // Register map, index times four is the byte address
  localparam int ADDR_W = 12;
  localparam logic [11:0] IDX_SETTINGS = 12'h086;
  localparam logic [11:0] IDX_CTRL = 12'h080;
  localparam logic [11:0] IDX_MAX_SPEED = 12'h081;
  localparam logic [11:0] IDX_STATUS = 12'h082;
  localparam logic [11:0] IDX_FREQ = 12'h083;
  localparam logic [11:0] ADDR_STEP = 12'h004;
  localparam logic [11:0] ADDR_SETTINGS = IDX_SETTINGS * ADDR_STEP;
  localparam logic [11:0] ADDR_CTRL = IDX_CTRL * ADDR_STEP;
  localparam logic [11:0] ADDR_MAX_SPEED = IDX_MAX_SPEED * ADDR_STEP;
  localparam logic [11:0] ADDR_STATUS = IDX_STATUS * ADDR_STEP;
  localparam logic [11:0] ADDR_FREQ = IDX_FREQ * ADDR_STEP;

  // ==========================================
  // Reset values and writable masks
  localparam logic [31:0] SETTINGS_RESET = 32'h0000_0000;
  localparam logic [31:0] SETTINGS_WMASK = 32'h7FFF_FFFF;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h01FF_0003;
  localparam logic [31:0] MAX_SPEED_RESET = 32'h0000_0064;
  localparam logic [31:0] MAX_SPEED_WMASK = 32'h0000_FFFF;

  // ==========================================
  // Field positions
  localparam int ILIM_LSB = 27;
  localparam int A1_LSB = 23;
  localparam int A2_LSB = 19;
  localparam int AUTO_BIT = 18;
  localparam int THR_LSB = 13;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_SRC_BIT = 1;
  localparam int CTRL_GCAP_LSB = 16;
  localparam int STATUS_DONE_BIT = 0;
  localparam int STATUS_STATE_LSB = 1;
  localparam int STATUS_SRC_BIT = 3;
  localparam int FREQ_RD_LSB = 16;

  // ==========================================
  // Value widths and scaling
  localparam int CAP_W = 9;
  localparam int RATE_W = 20;
  localparam int PCT_W = 7;
  localparam int ACC_W = 48;
  localparam logic [ACC_W-1:0] A1_SCALE = 48'h0000_0000_03E8;
  localparam logic [ACC_W-1:0] THR_SCALE = 48'h0000_0007_A120;
  localparam logic [PCT_W-1:0] THR_LOW_CODES = 7'h14;
  localparam logic [PCT_W-1:0] THR_LOW_STEP = 7'h02;
  localparam logic [PCT_W-1:0] THR_BASE_HALF = 7'h2D;
  localparam logic [PCT_W-1:0] THR_STEP_HALF = 7'h05;

  // Current in 1/128 A, top codes clamp to the highest limit
  localparam logic [CAP_W-1:0] CAP_TABLE [16] = '{
    9'h00A, 9'h014, 9'h028, 9'h050, 9'h078, 9'h0A0, 9'h0C8, 9'h0F0,
    9'h118, 9'h140, 9'h168, 9'h190, 9'h1B8, 9'h1E0, 9'h1E0, 9'h1E0};
  // Linear coefficient in 0.01 Hz/s
  localparam logic [RATE_W-1:0] A1_TABLE [16] = '{
    20'h0_0001, 20'h0_0005, 20'h0_0064, 20'h0_00FA,
    20'h0_01F4, 20'h0_03E8, 20'h0_09C4, 20'h0_1388,
    20'h0_1D4C, 20'h0_2710, 20'h0_61A8, 20'h0_C350,
    20'h1_24F8, 20'h1_86A0, 20'h7_A120, 20'hF_4240};
  // Quadratic coefficient in 0.01 Hz/s2
  localparam logic [RATE_W-1:0] A2_TABLE [16] = '{
    20'h0_0000, 20'h0_0005, 20'h0_0064, 20'h0_00FA,
    20'h0_01F4, 20'h0_03E8, 20'h0_09C4, 20'h0_1388,
    20'h0_1D4C, 20'h0_2710, 20'h0_61A8, 20'h0_C350,
    20'h1_24F8, 20'h1_86A0, 20'h7_A120, 20'hF_4240};

  typedef enum logic [1:0] {OLSC_IDLE, OLSC_RAMP, OLSC_CLOSED} olsc_state_t;
endpackage
`default_nettype wire

/* File: design/olsc_cfg_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface olsc_cfg_if;
  import olsc_pkg::*;
  logic [3:0] ilim_code;
  logic [3:0] a1_code;
  logic [3:0] a2_code;
  logic [4:0] thr_code;
  logic auto_en;
  logic run;
  logic [15:0] max_speed;
  logic [CAP_W-1:0] table_cap;
  logic [RATE_W-1:0] a1_rate;
  logic [RATE_W-1:0] a2_rate;
  logic [PCT_W-1:0] thr_half_pct;
  modport regs (output ilim_code, a1_code, a2_code, thr_code, auto_en, run,
    max_speed, input table_cap);
  modport lut (input ilim_code, a1_code, a2_code, thr_code,
    output table_cap, a1_rate, a2_rate, thr_half_pct);
  modport ramp (input auto_en, run, max_speed, a1_rate, a2_rate, thr_half_pct);
endinterface
`default_nettype wire

/* File: design/olsc_lut.sv */
`timescale 1ns/1ps
`default_nettype none
module olsc_lut (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  olsc_cfg_if.lut cfg
);
  import olsc_pkg::*;

  // ==========================================
  // Code to value decode
  wire [PCT_W-1:0] thr_code7;
  assign thr_code7 = {2'b00, cfg.thr_code};
  assign cfg.table_cap = CAP_TABLE[cfg.ilim_code];
  assign cfg.a1_rate = A1_TABLE[cfg.a1_code];
  assign cfg.a2_rate = A2_TABLE[cfg.a2_code];
  assign cfg.thr_half_pct = (thr_code7 < THR_LOW_CODES) ?
    (thr_code7 + 7'h01) * THR_LOW_STEP :
    THR_BASE_HALF + (thr_code7 - THR_LOW_CODES) * THR_STEP_HALF;

  // ==========================================
  // Checks
  AST_A1_RANGE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (cfg.a1_code == 4'h0 |-> cfg.a1_rate == 20'h0_0001) and
    (cfg.a1_code == 4'hF |-> cfg.a1_rate == 20'hF_4240))
    else $error("Linear coefficient decode wrong");
  AST_A2_ZERO: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (cfg.a2_code == 4'h0) |-> (cfg.a2_rate == 20'h0_0000))
    else $error("Quadratic code zero not zero");
  AST_THR_STEPS: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (cfg.thr_code == 5'h13 |-> cfg.thr_half_pct == 7'h28) and
    (cfg.thr_code == 5'h14 |-> cfg.thr_half_pct == 7'h2D) and
    (cfg.thr_code == 5'h1F |-> cfg.thr_half_pct == 7'h64))
    else $error("Handover percentage decode wrong");
endmodule
`default_nettype wire

/* File: design/olsc_ramp.sv */
`timescale 1ns/1ps
`default_nettype none
module olsc_ramp #(
  parameter int P_TICK_CYCLES = olsc_pkg::RAMP_TICK_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  olsc_cfg_if.ramp cfg,
  input wire logic i_estimator_locked,
  output olsc_pkg::olsc_state_t o_state,
  output logic [olsc_pkg::ACC_W-1:0] o_freq,
  output logic o_handoff
);
  import olsc_pkg::*;
  localparam int CNT_W = $clog2(P_TICK_CYCLES);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(P_TICK_CYCLES - 1);

  if (P_TICK_CYCLES < 2) begin : g_bad_tick
    $error("Tick period too short");
  end

  olsc_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [ACC_W-1:0] rate_reg;
  logic [ACC_W-1:0] freq_reg;
  logic handoff_reg;

  // ==========================================
  // Handover decision and tick
  wire [ACC_W-1:0] thr_freq;
  wire thr_hit;
  wire hit;
  wire in_ramp;
  wire tick;
  wire [ACC_W-1:0] rate_next;
  wire [ACC_W-1:0] freq_next;
  assign thr_freq = ACC_W'(cfg.max_speed) * ACC_W'(cfg.thr_half_pct) * THR_SCALE;
  assign thr_hit = freq_reg >= thr_freq;
  assign hit = cfg.auto_en ? i_estimator_locked : thr_hit;
  assign in_ramp = (state_reg == OLSC_RAMP) && cfg.run;
  assign tick = in_ramp && (cnt_reg == CNT_LAST);
  assign rate_next = rate_reg + ACC_W'(cfg.a2_rate);
  assign freq_next = freq_reg + ACC_W'(cfg.a1_rate) * A1_SCALE + rate_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      OLSC_IDLE: if (cfg.run) state_next = OLSC_RAMP;
      OLSC_RAMP: begin
        if (!cfg.run) state_next = OLSC_IDLE;
        else if (hit) state_next = OLSC_CLOSED;
      end
      OLSC_CLOSED: if (!cfg.run) state_next = OLSC_IDLE;
    endcase
  end

  // ==========================================
  // Registers
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= OLSC_IDLE;
      handoff_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      handoff_reg <= in_ramp && hit;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= (!in_ramp || tick) ? '0 : cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rate_reg <= '0;
      freq_reg <= '0;
    end else if (state_reg == OLSC_IDLE) begin
      rate_reg <= '0;
      freq_reg <= '0;
    end else if (tick && !hit) begin
      rate_reg <= rate_next;
      freq_reg <= freq_next;
    end
  end

  assign o_state = state_reg;
  assign o_freq = freq_reg;
  assign o_handoff = handoff_reg;

  // ==========================================
  // Checks
  sequence s_locked_in_ramp;
    in_ramp && cfg.auto_en && i_estimator_locked;
  endsequence
  sequence s_growing_tick;
    tick && !hit && (cfg.a1_rate != '0);
  endsequence
  AST_AUTO_HANDOVER: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    s_locked_in_ramp |=> (state_reg == OLSC_CLOSED) && o_handoff)
    else $error("Auto handover not taken");
  AST_FREQ_RISES: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    s_growing_tick |=> (freq_reg > $past(freq_reg)) ##1
    (freq_reg == $past(freq_reg)) || !in_ramp)
    else $error("Open loop frequency did not rise");
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import olsc_pkg::*;
  // ==========================================
  // Clock, reset, stimulus
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic est_locked = 1'b0;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  logic [CAP_W-1:0] o_ol_current_cap;
  logic [ACC_W-1:0] o_ol_freq;
  logic [1:0] o_ramp_state;
  logic o_handoff;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  int a1_val [16] = '{1, 5, 100, 250, 500, 1000, 2500, 5000, 7500, 10000, 25000, 50000,
    75000, 100000, 500000, 1000000};
  int thr_codes [4] = '{0, 19, 20, 31};
  logic [31:0] q;
  logic [47:0] f;
  logic [47:0] r;
  logic [47:0] thr;
  int half;

  initial begin
    forever #25 i_mclk = ~i_mclk;
  end

  olsc_startup_cfg #(.P_TICK_CYCLES(20)) olsc_startup_cfg_inst (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_avs_address(avs_address),
    .i_avs_read(avs_read),
    .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata),
    .i_avs_byteenable(4'hF),
    .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .i_estimator_locked(est_locked),
    .o_ol_current_cap(o_ol_current_cap),
    .o_ol_freq(o_ol_freq),
    .o_ramp_state(o_ramp_state),
    .o_handoff(o_handoff)
  );

  // ==========================================
  // Verdict and hang guard
  task automatic results();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      results();
    end
  end

  // ==========================================
  // Bus and compare helpers
  task automatic check(input string name, input logic [47:0] exp, input logic [47:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge i_mclk);
    end while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wait_freq(input logic [47:0] prev);
    int n;
    n = 0;
    do begin
      @(negedge i_mclk);
      n++;
    end while (o_ol_freq === prev && n < 200);
    if (n >= 200) error_cnt++;
  endtask

  task automatic wait_handoff(input int lim);
    int n;
    n = 0;
    while (o_handoff !== 1'b1 && n < lim) begin
      @(negedge i_mclk);
      n++;
    end
    check("handoff pulse", 48'h1, {47'h0, o_handoff});
    @(negedge i_mclk);
    check("handoff width", 48'h0, {47'h0, o_handoff});
  endtask

  function automatic logic [47:0] cap_exp(input int k);
    return (k == 0) ? 48'd10 : (k == 1) ? 48'd20 : (k == 2) ? 48'd40 : 48'(80 + 40 * (k - 3));
  endfunction

  // ==========================================
  // Test sequence
  initial begin
    repeat (16) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    bus(1'b0, ADDR_SETTINGS, 32'h0);
    check("settings reset", 48'h0, {16'h0, q});
    @(negedge i_mclk);
    check("cap reset", cap_exp(0), {39'h0, o_ol_current_cap});
    bus(1'b1, ADDR_SETTINGS, 32'hFFFF_FFFF);
    bus(1'b0, ADDR_SETTINGS, 32'h0);
    check("settings readback", 48'h7FFF_FFFF, {16'h0, q});
    bus(1'b1, 12'h3FC, 32'hFFFF_FFFF);
    bus(1'b0, 12'h3FC, 32'h0);
    check("unmapped read", 48'h0, {16'h0, q});
    for (int k = 0; k < 14; k++) begin
      bus(1'b1, ADDR_SETTINGS, 32'(k) << 27);
      repeat (2) @(negedge i_mclk);
      check("table cap", cap_exp(k), {39'h0, o_ol_current_cap});
    end
    bus(1'b1, ADDR_CTRL, 32'h0123_0002);
    repeat (2) @(negedge i_mclk);
    check("general cap", 48'h123, {39'h0, o_ol_current_cap});
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("status source", 48'h8, {16'h0, q});
    bus(1'b1, ADDR_CTRL, 32'h0);
    repeat (2) @(negedge i_mclk);
    check("cap back", cap_exp(13), {39'h0, o_ol_current_cap});
    // Linear coefficient: first tick step for every code
    for (int k = 0; k < 16; k++) begin
      bus(1'b1, ADDR_SETTINGS, (32'(k) << 23) | 32'h0003_E000);
      bus(1'b1, ADDR_CTRL, 32'h1);
      wait_freq(48'h0);
      check("linear step", 48'(a1_val[k]) * 48'd1000, o_ol_freq);
      check("ramp state", 48'h1, {46'h0, o_ramp_state});
      bus(1'b1, ADDR_CTRL, 32'h0);
    end
    repeat (2) @(negedge i_mclk);
    check("idle state", 48'h0, {46'h0, o_ramp_state});
    // Quadratic term, lock ignored while auto handover is off
    est_locked <= 1'b1;
    for (int j = 0; j < 2; j++) begin
      bus(1'b1, ADDR_SETTINGS, ((j == 0) ? 32'h0010_0000 : 32'h0078_0000) | 32'h0003_E000);
      bus(1'b1, ADDR_CTRL, 32'h1);
      f = 48'h0;
      r = 48'h0;
      for (int i = 0; i < 4; i++) begin
        wait_freq(f);
        f = f + 48'd1000 + r;
        r = r + ((j == 0) ? 48'd100 : 48'd1000000);
        check("quadratic ramp", f, o_ol_freq);
      end
      check("no auto handoff", 48'h1, {46'h0, o_ramp_state});
      bus(1'b1, ADDR_CTRL, 32'h0);
    end
    est_locked <= 1'b0;
    // Manual handover thresholds at both step sizes
    bus(1'b1, ADDR_MAX_SPEED, 32'h0000_0004);
    for (int t = 0; t < 4; t++) begin
      half = (thr_codes[t] < 20) ? 2 * (thr_codes[t] + 1) : 45 + 5 * (thr_codes[t] - 20);
      thr = 48'(4 * half) * 48'd500000;
      bus(1'b1, ADDR_SETTINGS, 32'h0480_0000 | (32'(thr_codes[t]) << 13));
      bus(1'b1, ADDR_CTRL, 32'h1);
      wait_handoff(1000);
      check("handoff speed", 48'h1, {47'h0, o_ol_freq >= thr && o_ol_freq < thr + 48'd10000000});
      @(negedge i_mclk);
      check("closed state", 48'h2, {46'h0, o_ramp_state});
      bus(1'b0, ADDR_STATUS, 32'h0);
      check("status done", 48'h5, {16'h0, q});
      bus(1'b1, ADDR_STATUS, 32'h1);
      bus(1'b0, ADDR_STATUS, 32'h0);
      check("status cleared", 48'h4, {16'h0, q});
      bus(1'b1, ADDR_CTRL, 32'h0);
    end
    // Automatic handover on estimator lock
    bus(1'b1, ADDR_MAX_SPEED, 32'h0000_0064);
    bus(1'b1, ADDR_SETTINGS, 32'h0004_0000);
    bus(1'b1, ADDR_CTRL, 32'h1);
    repeat (100) @(negedge i_mclk);
    check("auto waits lock", 48'h1, {46'h0, o_ramp_state});
    @(posedge i_mclk);
    est_locked <= 1'b1;
    wait_handoff(10);
    @(negedge i_mclk);
    check("auto closed", 48'h2, {46'h0, o_ramp_state});
    bus(1'b1, ADDR_CTRL, 32'h0);
    results();
  end
endmodule
`default_nettype wire
